// ### rtl/derp_defines.svh
// Offsets, field positions, reset values and timing counts of the row programmer.
`ifndef DERP_DEFINES_SVH
`define DERP_DEFINES_SVH
`define DERP_CTRL_OFF 8'h30
`define DERP_STS_OFF 8'h34
`define DERP_MSK_OFF 8'h38
`define DERP_CYC_OFF 8'h3c
`define DERP_LAT_BIT 1
`define DERP_PGM_BIT 0
`define DERP_EV_DONE 0
`define DERP_EV_ERR 1
`define DERP_CLK_NS 5
`define DERP_PROG_NS 5000
`define DERP_PROG_CYC (`DERP_PROG_NS / `DERP_CLK_NS)
`define DERP_ERASED 8'hff
`define DERP_RESP_OK 2'h0
`define DERP_RESP_ERR 2'h2
`endif

// ### rtl/derp_pkg.sv
// Types shared by the row programmer and its users.
package derp_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_PROG = 5'h02,
        ST_WAIT = 5'h04,
        ST_HALT = 5'h08,
        ST_ERASE = 5'h10
    } derp_state_t;

    typedef enum logic [2:0] {
        RG_NONE, RG_CTRL, RG_STS, RG_MSK, RG_CYC
    } derp_reg_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } derp_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } derp_axi_rsp_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } derp_mem_req_t;

endpackage : derp_pkg

// ### rtl/derp_top.sv
// Data EEPROM row programmer with AXI4-Lite control registers.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "derp_defines.svh"

module derp_top (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Register bus.
    input wire derp_pkg::derp_axi_req_t axi_i,
    output wire derp_pkg::derp_axi_rsp_t axi_o,
    // Core memory bus.
    input wire derp_pkg::derp_mem_req_t mem_i,
    output wire logic [7:0] mem_rdata_o,
    output wire logic mem_rdrive_o,
    // Power modes and protection option.
    input wire logic wfi_i,
    input wire logic halt_i,
    input wire logic rop_i,
    output wire logic eep_wait_o,
    output wire logic eep_halt_o,
    output wire logic pmem_erase_o,
    // Interrupt.
    output wire logic irq_o
);
    import derp_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    typedef struct packed {
        derp_state_t st;
        logic lat;
        logic program_bit;
        logic [15:0] cyc_cfg;
        logic [15:0] cnt;
        logic [1:0] sts;
        logic [1:0] msk;
        logic irq;
        logic rop_q;
        logic pm_erase;
        logic [2:0] row;
        logic [31:0] lvld;
        logic [31:0][7:0] ltch;
        logic [255:0][7:0] mem;
        logic [7:0] rdata;
        logic rdrive;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        derp_axi_rsp_t ax;
    } derp_core_t;

    derp_core_t q;
    derp_core_t next_q;
    logic [1:0] ev;
    logic acc;
    logic done;

    // Register offset decode, shared by the read and write paths.
    function automatic derp_reg_t reg_dec(input logic [7:0] a);
        case (a)
            `DERP_CTRL_OFF: return RG_CTRL;
            `DERP_STS_OFF: return RG_STS;
            `DERP_MSK_OFF: return RG_MSK;
            `DERP_CYC_OFF: return RG_CYC;
            default: return RG_NONE;
        endcase
    endfunction : reg_dec

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Power, array access and programming sequencer, then bus writes.
    always_comb begin
        next_q = q;
        next_q.rdrive = 1'b0;
        next_q.pm_erase = 1'b0;
        next_q.rop_q = rop_i;
        ev = 2'h0;
        acc = 1'b0;
        done = 1'b0;
        if (halt_i) begin
            next_q.st = ST_HALT;
            next_q.program_bit = 1'b0;
            next_q.lat = 1'b0;
        end else if (q.rop_q && !rop_i) begin
            next_q.st = ST_ERASE;
            next_q.pm_erase = 1'b1;
            next_q.program_bit = 1'b0;
            next_q.lat = 1'b0;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    if (wfi_i) begin
                        next_q.st = ST_WAIT;
                    end else if (mem_i.req) begin
                        acc = 1'b1;
                        if (mem_i.we) begin
                            if (q.lat && !rop_i) begin
                                // Repeated writes over-program by AND.
                                next_q.ltch[mem_i.addr[4:0]] = q.lvld[mem_i.addr[4:0]] ?
                                    (q.ltch[mem_i.addr[4:0]] & mem_i.wdata) : mem_i.wdata;
                                next_q.lvld[mem_i.addr[4:0]] = 1'b1;
                                next_q.row = mem_i.addr[7:5];
                            end else begin
                                ev[`DERP_EV_ERR] = 1'b1;
                            end
                        end else if (!q.lat && !rop_i) begin
                            next_q.rdata = q.mem[mem_i.addr];
                            next_q.rdrive = 1'b1;
                        end else begin
                            ev[`DERP_EV_ERR] = 1'b1;
                        end
                    end
                end
                ST_PROG: begin
                    next_q.cnt = q.cnt - 16'h1;
                    if (q.cnt <= 16'h1) begin
                        done = 1'b1;
                        for (int i = 0; i < 32; i++) begin
                            if (q.lvld[i]) begin
                                next_q.mem[{q.row, 5'(i)}] = q.ltch[i];
                            end
                        end
                        next_q.program_bit = 1'b0;
                        next_q.lat = 1'b0;
                        ev[`DERP_EV_DONE] = 1'b1;
                        next_q.st = wfi_i ? ST_WAIT : ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    if (!wfi_i) begin
                        next_q.st = ST_IDLE;
                    end
                end
                ST_HALT: begin
                    next_q.st = ST_IDLE;
                end
                ST_ERASE: begin
                    next_q.mem = {256{`DERP_ERASED}};
                    next_q.st = ST_IDLE;
                end
                default: begin
                    next_q.st = ST_IDLE;
                end
            endcase
        end

        // Write address and data are taken in either order.
        if (axi_i.awvalid && q.ax.awready) begin
            next_q.awaddr = axi_i.awaddr;
            next_q.ax.awready = 1'b0;
        end
        if (axi_i.wvalid && q.ax.wready) begin
            next_q.wdata = axi_i.wdata;
            next_q.wstrb = axi_i.wstrb;
            next_q.ax.wready = 1'b0;
        end
        if (q.ax.bvalid && axi_i.bready) begin
            next_q.ax.bvalid = 1'b0;
            next_q.ax.awready = 1'b1;
            next_q.ax.wready = 1'b1;
        end

        // Commit a register write once both halves are held.
        if (!q.ax.awready && !q.ax.wready && !q.ax.bvalid) begin
            next_q.ax.bvalid = 1'b1;
            next_q.ax.bresp = `DERP_RESP_OK;
            case (reg_dec(q.awaddr))
                RG_CTRL: begin
                    if (q.wstrb[0]) begin
                        if (next_q.program_bit) begin
                            // Latch mode cannot be cleared during a cycle.
                            if (!q.wdata[`DERP_PGM_BIT]) begin
                                next_q.program_bit = 1'b0;
                                next_q.st = ST_IDLE;
                            end
                        end else begin
                            next_q.lat = q.wdata[`DERP_LAT_BIT];
                            if (q.wdata[`DERP_PGM_BIT] && q.wdata[`DERP_LAT_BIT] && !rop_i &&
                                next_q.st == ST_IDLE) begin
                                next_q.program_bit = 1'b1;
                                next_q.cnt = q.cyc_cfg;
                                next_q.st = ST_PROG;
                            end
                        end
                    end
                end
                RG_STS: begin
                    if (q.wstrb[0]) begin
                        next_q.sts = q.sts & ~q.wdata[1:0];
                    end
                end
                RG_MSK: begin
                    if (q.wstrb[0]) begin
                        next_q.msk = q.wdata[1:0];
                    end
                end
                RG_CYC: begin
                    if (q.wstrb[0]) begin
                        next_q.cyc_cfg[7:0] = q.wdata[7:0];
                    end
                    if (q.wstrb[1]) begin
                        next_q.cyc_cfg[15:8] = q.wdata[15:8];
                    end
                end
                default: begin
                    next_q.ax.bresp = `DERP_RESP_ERR;
                end
            endcase
        end

        // Latches empty whenever latch mode falls.
        if (q.lat && !next_q.lat) begin
            next_q.lvld = 32'h0;
        end

        // Register reads answer one cycle after the address is taken.
        if (q.ax.rvalid && axi_i.rready) begin
            next_q.ax.rvalid = 1'b0;
            next_q.ax.arready = 1'b1;
        end
        if (axi_i.arvalid && q.ax.arready) begin
            next_q.ax.arready = 1'b0;
            next_q.ax.rvalid = 1'b1;
            next_q.ax.rresp = `DERP_RESP_OK;
            case (reg_dec(axi_i.araddr))
                RG_CTRL: next_q.ax.rdata = {30'h0, q.lat, q.program_bit};
                RG_STS: next_q.ax.rdata = {30'h0, q.sts};
                RG_MSK: next_q.ax.rdata = {30'h0, q.msk};
                RG_CYC: next_q.ax.rdata = {16'h0, q.cyc_cfg};
                default: begin
                    next_q.ax.rdata = 32'h0;
                    next_q.ax.rresp = `DERP_RESP_ERR;
                end
            endcase
        end

        // Sticky events; a new event wins over a same-cycle clear.
        next_q.sts = next_q.sts | ev;
        next_q.irq = |(next_q.sts & next_q.msk);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Reset clears control state; the array itself is nonvolatile.
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.cyc_cfg <= 16'(`DERP_PROG_CYC);
            q.ax.awready <= 1'b1;
            q.ax.wready <= 1'b1;
            q.ax.arready <= 1'b1;
            q.mem <= q.mem;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from state flops.
    assign axi_o = q.ax;
    assign mem_rdata_o = q.rdata;
    assign mem_rdrive_o = q.rdrive;
    assign eep_wait_o = q.st[2];
    assign eep_halt_o = q.st[3];
    assign pmem_erase_o = q.pm_erase;
    assign irq_o = q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    logic [7:0] h_rd;
    logic [7:0] h_lt;
    logic [4:0] h_ix;
    logic [7:0] h_l0;
    logic [7:0] h_wr;
    assign h_rd = q.mem[mem_i.addr];
    assign h_ix = mem_i.addr[4:0];
    assign h_lt = q.ltch[mem_i.addr[4:0]];
    assign h_l0 = q.ltch[0];
    assign h_wr = {q.row, 5'h0};

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // Read mode returns the cell contents.
    property p_rd;
        acc && !mem_i.we && !q.lat && !rop_i |=> mem_rdrive_o && mem_rdata_o == $past(h_rd);
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");

    // Latch mode write marks its latch.
    property p_latch;
        acc && mem_i.we && q.lat && !rop_i |=> q.lvld[$past(h_ix)];
    endproperty
    a_latch: assert property (p_latch) else $error("latch not marked");

    // Completion writes latch zero into the row.
    property p_commit;
        done && q.lvld[0] |=> q.mem[$past(h_wr)] == $past(h_l0);
    endproperty
    a_commit: assert property (p_commit) else $error("row not programmed");

    // Cycle end drops both control bits together.
    property p_end;
        done |=> !q.program_bit && !q.lat && q.lvld == 32'h0;
    endproperty
    a_end: assert property (p_end) else $error("bits not cleared");

    // Rewrites merge by AND.
    property p_and;
        acc && mem_i.we && q.lat && !rop_i && q.lvld[h_ix] |=> q.ltch[$past(h_ix)] == ($past(h_lt) & $past(mem_i.wdata));
    endproperty
    a_and: assert property (p_and) else $error("latch merge wrong");

    // Latch mode never drives read data.
    property p_undrv;
        q.lat |=> !mem_rdrive_o;
    endproperty
    a_undrv: assert property (p_undrv) else $error("bus driven in latch mode");

    // Read mode writes leave the latches alone.
    property p_drop;
        acc && mem_i.we && !q.lat |=> $stable(q.lvld);
    endproperty
    a_drop: assert property (p_drop) else $error("write latched in read mode");

    // Idle wait request enters wait next cycle.
    property p_wait;
        q.st == ST_IDLE && wfi_i && !halt_i && !(q.rop_q && !rop_i) |=> eep_wait_o;
    endproperty
    a_wait: assert property (p_wait) else $error("wait not entered");

    // Halt aborts at once.
    property p_halt;
        halt_i |=> eep_halt_o && !q.program_bit;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not entered");

    // Protection blocks reads.
    property p_rop;
        mem_i.req && !mem_i.we && rop_i |=> !mem_rdrive_o;
    endproperty
    a_rop: assert property (p_rop) else $error("protected read driven");

    // Removal erases the array two cycles later.
    property p_erase;
        q.rop_q && !rop_i && !halt_i |=> pmem_erase_o ##1 q.mem[0] == `DERP_ERASED;
    endproperty
    a_erase: assert property (p_erase) else $error("erase missing");

    // Control read shows zero above bit 1.
    property p_ctl;
        axi_i.arvalid && axi_o.arready && axi_i.araddr == `DERP_CTRL_OFF |=> axi_o.rvalid && axi_o.rdata[31:2] == 30'h0;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control high bits set");

    // A running cycle shows program start and starts from the set count.
    property p_busy;
        $rose(q.program_bit) |-> q.st == ST_PROG && q.cnt == q.cyc_cfg;
    endproperty
    a_busy: assert property (p_busy) else $error("cycle start wrong");

    c_done: cover property (done);
    c_erase: cover property (pmem_erase_o);
    c_wait: cover property (q.st == ST_PROG && wfi_i ##1 eep_wait_o);

endmodule : derp_top
`default_nettype wire

// ### verification/derp_cpu_model.sv
// Core-side model that issues byte reads and writes on the memory bus.
`timescale 1ns/1ps
`default_nettype none
module derp_cpu_model (
    // Clock.
    input wire logic clk_sys_i,
    // Memory bus.
    output var derp_pkg::derp_mem_req_t mem_o,
    input wire logic [7:0] rdata_i,
    input wire logic rdrive_i
);
    import derp_pkg::*;
    initial mem_o = '0;
    // One request cycle, then the lines flip so stale values never look valid.
    task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        mem_o <= '{req: 1'b1, we: we, addr: a, wdata: d};
        @(posedge clk_sys_i);
        mem_o <= '{req: 1'b0, we: ~we, addr: ~a, wdata: ~d};
    endtask : acc
    // Byte write; callers keep every byte of one cycle in one row.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask : wr
    // Byte read; data and drive flag as seen in the answer cycle.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic drv);
        acc(1'b0, a, 8'h00);
        #1;
        d = rdata_i;
        drv = rdrive_i;
    endtask : rd
endmodule : derp_cpu_model
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the data EEPROM row programmer.
`timescale 1ns/1ps
`default_nettype none
`include "derp_defines.svh"
module tb;
    import derp_pkg::*;
    localparam logic [7:0] CTRL = `DERP_CTRL_OFF;
    localparam logic [7:0] STS = `DERP_STS_OFF;
    localparam logic [7:0] MSK = `DERP_MSK_OFF;
    localparam logic [7:0] CYC = `DERP_CYC_OFF;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wait_for_interrupt_instr = 1'b0;
    logic halt = 1'b0;
    logic rop = 1'b1;
    derp_axi_req_t axi_q = '0;
    derp_axi_rsp_t axi_o;
    derp_mem_req_t mem_q;
    logic [7:0] mem_rdata;
    logic mem_rdrive, eep_wait, eep_halt, erase, irq;
    logic [31:0] rd_data;
    logic [1:0] resp;
    int error_cnt = 0;
    int n_compared = 0;
    int n_erase = 0;
    int cyc = 0;

    derp_top uut (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .axi_i(axi_q),
        .axi_o(axi_o),
        .mem_i(mem_q),
        .mem_rdata_o(mem_rdata),
        .mem_rdrive_o(mem_rdrive),
        .wfi_i(wait_for_interrupt_instr),
        .halt_i(halt),
        .rop_i(rop),
        .eep_wait_o(eep_wait),
        .eep_halt_o(eep_halt),
        .pmem_erase_o(erase),
        .irq_o(irq)
    );
    derp_cpu_model cpu (
        .clk_sys_i(clk_sys_i),
        .mem_o(mem_q),
        .rdata_i(mem_rdata),
        .rdrive_i(mem_rdrive)
    );

    // Clock, cycle count and erase pulse count.
    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (erase) n_erase <= n_erase + 1;
    end

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task automatic lose(input string nm);
        error_cnt++;
        $display("unexpected %s: expected answer, seen timeout", nm);
        conclude();
    endtask : lose

    // Register write; payload held on each channel until its ready.
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        axi_q <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hf, bready: 1'b1, default: '0};
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys_i);
            if (axi_q.awvalid && axi_o.awready) axi_q.awvalid <= 1'b0;
            if (axi_q.wvalid && axi_o.wready) axi_q.wvalid <= 1'b0;
            if (axi_o.bvalid) break;
        end
        resp = axi_o.bresp;
        axi_q.bready <= 1'b0;
        if (n == 64) lose("write response");
    endtask : axw

    // Register read; data and response taken at the rvalid edge.
    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge clk_sys_i);
        axi_q <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys_i);
            if (axi_q.arvalid && axi_o.arready) axi_q.arvalid <= 1'b0;
            if (axi_o.rvalid) break;
        end
        rd_data = axi_o.rdata;
        resp = axi_o.rresp;
        axi_q.rready <= 1'b0;
        if (n == 64) lose("read response");
    endtask : axr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk(nm, e, rd_data);
    endtask : rchk

    task automatic mchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic drv;
        cpu.rd(a, v, drv);
        chk("mem drive", 32'h1, 32'(drv));
        chk("mem data", 32'(e), 32'(v));
    endtask : mchk

    // Polls control until the cycle ends; it must read 3 until then 0.
    task automatic wait_done(input int t0, input int lo);
        int n;
        for (n = 0; n < 300; n++) begin
            axr(CTRL);
            if (rd_data === 32'h0) break;
            chk("ctrl in cycle", 32'h3, rd_data);
        end
        if (n == 300) lose("cycle end");
        chk("ctrl after cycle", 32'h0, rd_data);
        chk("cycle long enough", 32'h1, 32'(cyc - t0 >= lo));
    endtask : wait_done

    task automatic s_protect();
        logic [7:0] v;
        logic drv;
        cpu.rd(8'h10, v, drv);
        chk("protected read drive", 32'h0, 32'(drv));
        rchk("status access error", STS, 32'h2);
        axw(STS, 32'h3);
        // Latch mode under protection: writes are refused and no cycle may start.
        axw(CTRL, 32'h2);
        cpu.wr(8'h10, 8'h00);
        rchk("protected write refused", STS, 32'h2);
        axw(CTRL, 32'h3);
        rchk("protected start refused", CTRL, 32'h2);
        axw(CTRL, 32'h0);
        @(posedge clk_sys_i) rop <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk("erase pulses", 32'h1, 32'(n_erase));
        mchk(8'h10, `DERP_ERASED);
        mchk(8'hff, `DERP_ERASED);
    endtask : s_protect

    task automatic s_regs();
        rchk("ctrl reset", CTRL, 32'h0);
        rchk("mask reset", MSK, 32'h0);
        axw(8'h40, 32'h1);
        chk("unmapped write resp", 32'(`DERP_RESP_ERR), 32'(resp));
        axr(8'h40);
        chk("unmapped read resp", 32'(`DERP_RESP_ERR), 32'(resp));
        axw(CTRL, 32'hfe);
        chk("ctrl write resp", 32'(`DERP_RESP_OK), 32'(resp));
        rchk("ctrl reserved bits", CTRL, 32'h2);
        axw(CTRL, 32'h0);
        rchk("ctrl latch cleared", CTRL, 32'h0);
    endtask : s_regs

    task automatic s_program();
        logic [7:0] v;
        logic drv;
        int t0;
        axw(STS, 32'h3);
        axw(CYC, 32'd60);
        axw(MSK, 32'h1);
        axw(CTRL, 32'h2);
        cpu.rd(8'h45, v, drv);
        chk("latch mode read drive", 32'h0, 32'(drv));
        cpu.wr(8'h45, 8'h3c);
        cpu.wr(8'h45, 8'h0f);
        cpu.wr(8'h40, 8'h5a);
        cpu.wr(8'h5f, 8'ha5);
        #1;
        chk("irq masked", 32'h0, 32'(irq));
        axw(CTRL, 32'h3);
        t0 = cyc;
        rchk("ctrl cycle running", CTRL, 32'h3);
        axw(CTRL, 32'h1);
        rchk("ctrl latch clear refused", CTRL, 32'h3);
        wait_done(t0, 55);
        #1;
        chk("irq on done", 32'h1, 32'(irq));
        rchk("status done and error", STS, 32'h3);
        axw(STS, 32'h3);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("irq cleared", 32'h0, 32'(irq));
        mchk(8'h45, 8'h0c);
        mchk(8'h40, 8'h5a);
        mchk(8'h5f, 8'ha5);
        mchk(8'h41, `DERP_ERASED);
    endtask : s_program

    task automatic s_drop();
        int t0;
        cpu.wr(8'h80, 8'h00);
        axw(CTRL, 32'h2);
        cpu.wr(8'h81, 8'h00);
        axw(CTRL, 32'h0);
        axw(CTRL, 32'h2);
        cpu.wr(8'h82, 8'h77);
        axw(CTRL, 32'h3);
        t0 = cyc;
        wait_done(t0, 55);
        mchk(8'h80, `DERP_ERASED);
        mchk(8'h81, `DERP_ERASED);
        mchk(8'h82, 8'h77);
    endtask : s_drop

    task automatic s_wait();
        int n;
        @(posedge clk_sys_i) wait_for_interrupt_instr <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("idle wait entry", 32'h1, 32'(eep_wait));
        @(posedge clk_sys_i) wait_for_interrupt_instr <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        axw(CTRL, 32'h2);
        cpu.wr(8'ha0, 8'h12);
        axw(CTRL, 32'h3);
        @(posedge clk_sys_i) wait_for_interrupt_instr <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        #1;
        chk("wait held off in cycle", 32'h0, 32'(eep_wait));
        for (n = 0; n < 200 && eep_wait !== 1'b1; n++) @(posedge clk_sys_i);
        if (n == 200) lose("wait entry");
        #1;
        chk("wait after cycle", 32'h1, 32'(eep_wait));
        @(posedge clk_sys_i) wait_for_interrupt_instr <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rchk("ctrl after waited cycle", CTRL, 32'h0);
        mchk(8'ha0, 8'h12);
    endtask : s_wait

    task automatic s_halt();
        axw(CTRL, 32'h2);
        cpu.wr(8'hc0, 8'h34);
        axw(CTRL, 32'h3);
        @(posedge clk_sys_i) halt <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("halt entry", 32'h1, 32'(eep_halt));
        @(posedge clk_sys_i) halt <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rchk("ctrl after halt", CTRL, 32'h0);
        mchk(8'hc0, `DERP_ERASED);
    endtask : s_halt

    // Reset, then every scenario in turn.
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        s_protect();
        s_regs();
        s_program();
        s_drop();
        s_wait();
        s_halt();
        conclude();
    end
endmodule : tb
`default_nettype wire
